// ==== logic/cdp_device.sv ====
// Operation
// - Selected only when low select low, high select high
// - Write strobe low loads data byte into buffer
// - Read strobe low: top line status, others high
// - Both strobes low: write wins, byte loaded
// - Byte-wide daisy mode: high select is serial enable
// - After done, pins become ordinary user pins
// - Master parallel drives 18-bit memory address
// - Extended variant adds four more address bits
// - Parallel modes take bytes from the seven upper data lines plus serial input
// - Serial modes sample input on rising clock
// - Parallel modes use serial input as bit zero
// - Forward serial data on falling edge, 1.5 periods
// - Daisy mode: serial output enables next device
// - Pull init low on configuration data error
`timescale 1ns/100ps
module cdp_device
    import cdp_pkg::*;
#(
    parameter bit EXTENDED = 1'b1
)
(
    input  wire logic                    clock,
    input  wire logic                    nrst,
    cdp_if.dev                           link,
    input  wire cdp_mode_t               mode,
    input  wire logic                    config_done,
    input  wire logic                    data_error,
    input  wire logic                    chain_enable,
    output logic      [DATA_W-1:0]       byte_data,
    output logic                         byte_valid,
    input  wire logic                    byte_ready,
    output logic      [PIN_W-1:0]        user_pins_in,
    output logic      [DATA_W-1:0]       user_data_in,
    input  wire logic [DATA_W-1:0]       user_data_out,
    input  wire logic [DATA_W-1:0]       user_data_oe,
    input  wire logic                    user_serial_out,
    input  wire logic [FULL_ADDR_W-1:0]  user_address
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic is_serial(input cdp_mode_t m);
        return (m == MODE_MASTER_SERIAL) || (m == MODE_SLAVE_SERIAL);
    endfunction : is_serial

    ////////////////////////////////////////////////////////////////////////////////
    localparam int SYNC_W = PIN_W + 2 + DATA_W;
    localparam logic [SYNC_W-1:0] SYNC_INIT = {4'hB, 2'h0, BYTE_RST};

    logic [SYNC_W-1:0] sync_s;
    logic              csl_s;
    logic              csh_s;
    logic              ws_s;
    logic              rs_s;
    logic              configuration_clock_s;
    logic              din_s;
    logic [DATA_W-1:0] data_s;

    // Strobes and selects idle at their inactive levels
    cdp_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     ({link.chip_select_low_n, link.chip_select_high, link.write_strobe_n,
                 link.read_strobe_n, link.configuration_clock, link.serial_in,
                 link.data_line}),
        .q     (sync_s)
    );

    assign {csl_s, csh_s, ws_s, rs_s, configuration_clock_s, din_s, data_s} = sync_s;

    ////////////////////////////////////////////////////////////////////////////////
    logic configuration_clock_prev_q;
    logic configuration_clock_rise;
    logic configuration_clock_fall;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            configuration_clock_prev_q <= 1'b0;
        else
            configuration_clock_prev_q <= configuration_clock_s;
    end

    assign configuration_clock_rise = configuration_clock_s & ~configuration_clock_prev_q;
    assign configuration_clock_fall = ~configuration_clock_s & configuration_clock_prev_q;

    ////////////////////////////////////////////////////////////////////////////////
    logic              selected;
    logic              wr_low;
    logic              rd_low;
    logic [DATA_W-1:0] par_byte;

    assign selected = ~csl_s & csh_s & ~config_done & (mode == MODE_PERIPHERAL);
    assign wr_low   = selected & ~ws_s;
    assign rd_low   = selected & ~rs_s & ws_s;
    assign par_byte = {data_s[DATA_W-1:1], din_s};

    cdp_strobe_state_t st_q;
    cdp_strobe_state_t st_d;
    logic              periph_load;

    always_comb
    begin
        st_d        = st_q;
        periph_load = 1'b0;
        case (st_q)
            ST_IDLE:
            begin
                if (wr_low)
                begin
                    st_d        = ST_WRITE;
                    periph_load = 1'b1;
                end
                else if (rd_low)
                    st_d = ST_READ;
            end
            ST_WRITE:
            begin
                if (!wr_low)
                    st_d = ST_IDLE;
            end
            ST_READ:
            begin
                if (wr_low)
                begin
                    st_d        = ST_WRITE;
                    periph_load = 1'b1;
                end
                else if (!rd_low)
                    st_d = ST_IDLE;
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            st_q <= ST_IDLE;
        else
            st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] shift_q;
    logic [2:0]        bitcnt_q;
    logic              ser_load;
    logic              mp_load;
    logic              xp_load;

    assign ser_load = is_serial(mode) & configuration_clock_rise & (bitcnt_q == BITCNT_LAST) & ~config_done;
    assign mp_load  = (mode == MODE_MASTER_PARALLEL) & configuration_clock_rise & ~config_done;
    assign xp_load  = (mode == MODE_EXPRESS) & configuration_clock_rise & csh_s & ~config_done;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_q  <= BYTE_RST;
            bitcnt_q <= '0;
        end
        else if (is_serial(mode) && configuration_clock_rise && !config_done)
        begin
            shift_q  <= {shift_q[DATA_W-2:0], din_s};
            bitcnt_q <= bitcnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock-driven sources cannot be stalled: a byte arriving while full is dropped
    logic full_q;
    logic load;
    logic take;

    assign load = (periph_load | mp_load | xp_load | ser_load) & ~full_q;
    assign take = full_q & byte_ready;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            full_q    <= 1'b0;
            byte_data <= BYTE_RST;
        end
        else
        begin
            full_q <= load | (full_q & ~take);
            if (load)
                byte_data <= ser_load ? {shift_q[DATA_W-2:0], din_s} : par_byte;
        end
    end

    assign byte_valid = full_q;

    ////////////////////////////////////////////////////////////////////////////////
    logic [FULL_ADDR_W-1:0] addr_q;

    // Address advances once per byte fetched from memory
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            addr_q <= ADDR_RST;
        else if (mp_load)
            addr_q <= addr_q + 22'h000001;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            link.memory_address_out <= '0;
            link.extra_address_out  <= '0;
        end
        else if (config_done)
        begin
            link.memory_address_out <= user_address[ADDR_W-1:0];
            link.extra_address_out  <= user_address[FULL_ADDR_W-1:ADDR_W];
        end
        else
        begin
            link.memory_address_out <= addr_q[ADDR_W-1:0];
            link.extra_address_out  <= (EXTENDED && mode == MODE_MASTER_PARALLEL)
                                     ? addr_q[FULL_ADDR_W-1:ADDR_W] : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic stage1_q;
    logic stage2_q;
    logic fwd_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end
        else if (configuration_clock_rise)
        begin
            stage1_q <= din_s;
            stage2_q <= stage1_q;
        end
    end

    // Bit from rising edge k leaves on the falling edge after rising edge k+1
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            fwd_q <= 1'b0;
        else if (configuration_clock_fall)
            fwd_q <= stage2_q;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            link.serial_out <= 1'b0;
        else if (config_done)
            link.serial_out <= user_serial_out;
        else if (mode == MODE_EXPRESS)
            link.serial_out <= chain_enable;
        else
            link.serial_out <= fwd_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            link.dev_data_out <= BUS_IDLE;
            link.dev_data_oe  <= '0;
        end
        else if (config_done)
        begin
            link.dev_data_out <= user_data_out;
            link.dev_data_oe  <= user_data_oe;
        end
        else
        begin
            link.dev_data_out <= {~full_q, STATUS_FILL};
            link.dev_data_oe  <= {DATA_W{rd_low}};
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            link.init_oe <= 1'b0;
        else
            link.init_oe <= data_error & ~config_done;
    end

    assign link.init_out = 1'b0;

    // Synchronised pin levels for user logic once configuration is over
    assign user_pins_in = {csl_s, csh_s, ws_s, rs_s};
    assign user_data_in = data_s;

endmodule : cdp_device

// ==== logic/cdp_pkg.sv ====
package cdp_pkg;

    // Widths of the pin groups
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 18;
    localparam int XADDR_W    = 4;
    localparam int FULL_ADDR_W = ADDR_W + XADDR_W;
    localparam int PIN_W      = 4;

    // Field positions on the data lines
    localparam int STATUS_BIT = 7;
    localparam int D0_BIT     = 0;
    localparam logic [DATA_W-2:0] STATUS_FILL = 7'h7F;
    localparam logic [DATA_W-1:0] BUS_IDLE    = 8'hFF;

    // Reset values and last bit count
    localparam logic [FULL_ADDR_W-1:0] ADDR_RST = 22'h000000;
    localparam logic [DATA_W-1:0]      BYTE_RST = 8'h00;
    localparam logic [2:0]             BITCNT_LAST = 3'h7;

    // Configuration modes
    typedef enum logic [2:0] {
        MODE_MASTER_SERIAL   = 3'h0,
        MODE_SLAVE_SERIAL    = 3'h7,
        MODE_MASTER_PARALLEL = 3'h3,
        MODE_PERIPHERAL      = 3'h5,
        MODE_EXPRESS         = 3'h6
    } cdp_mode_t;

    // Strobe tracking in the device
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WRITE = 2'h1,
        ST_READ  = 2'h3
    } cdp_strobe_state_t;

    // Host access sequencer
    typedef enum logic [1:0] {
        H_IDLE  = 2'h0,
        H_WRITE = 2'h1,
        H_READ  = 2'h3,
        H_GAP   = 2'h2
    } cdp_host_state_t;

    // Timing
    localparam int CLK_MHZ      = 200;
    localparam int STROBE_NS    = 60;
    localparam int GAP_NS       = 30;
    localparam int CONFIGURATION_CLOCK_HALF_NS = 160;
    localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC      = (GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int CONFIGURATION_CLOCK_HALF_CYC = (CONFIGURATION_CLOCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 8;

endpackage : cdp_pkg

// ==== logic/cdp_if.sv ====
`timescale 1ns/100ps
interface cdp_if;
    import cdp_pkg::*;

    logic                 chip_select_low_n;
    logic                 chip_select_high;
    logic                 write_strobe_n;
    logic                 read_strobe_n;
    logic                 configuration_clock;
    logic                 serial_in;
    logic                 serial_out;
    logic [ADDR_W-1:0]    memory_address_out;
    logic [XADDR_W-1:0]   extra_address_out;
    logic [DATA_W-1:0]    dev_data_out;
    logic [DATA_W-1:0]    dev_data_oe;
    logic [DATA_W-1:0]    host_data_out;
    logic                 host_data_oe;
    logic [DATA_W-1:0]    data_line;
    logic                 init_out;
    logic                 init_oe;
    logic                 init_line;

    // Pulled-up wires; a device drive wins over the host on the data lines
    genvar i;
    for (i = 0; i < DATA_W; i++)
    begin : g_line
        assign data_line[i] = dev_data_oe[i] ? dev_data_out[i]
                            : (host_data_oe ? host_data_out[i] : BUS_IDLE[i]);
    end
    assign init_line = init_oe ? init_out : 1'b1;

    modport dev (
        input  chip_select_low_n, chip_select_high, write_strobe_n, read_strobe_n,
        input  configuration_clock, serial_in, data_line, init_line,
        output serial_out, memory_address_out, extra_address_out,
        output dev_data_out, dev_data_oe, init_out, init_oe
    );

    modport host (
        output chip_select_low_n, chip_select_high, write_strobe_n, read_strobe_n,
        output configuration_clock, serial_in, host_data_out, host_data_oe,
        input  data_line, serial_out, init_line, memory_address_out, extra_address_out
    );

endinterface : cdp_if

// ==== logic/cdp_sync.sv ====
`timescale 1ns/100ps
module cdp_sync
#(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Only the second stage is visible outside
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= INIT;
            q      <= INIT;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : cdp_sync

// ==== logic/cdp_host.sv ====
`timescale 1ns/100ps
module cdp_host
    import cdp_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              nrst,
    cdp_if.host                    link,
    input  wire logic              wr_valid,
    input  wire logic [DATA_W-1:0] wr_byte,
    output logic                   wr_ready,
    input  wire logic              rd_valid,
    output logic                   rd_ready,
    output logic                   status_ready,
    output logic                   status_valid,
    input  wire logic              ser_valid,
    input  wire logic [DATA_W-1:0] ser_byte,
    output logic                   ser_ready
);

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST    = CNT_W'(GAP_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LAST   = CNT_W'(CONFIGURATION_CLOCK_HALF_CYC - 1);

    logic status_s;

    cdp_sync #(.W(1), .INIT(1'b0)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     (link.data_line[STATUS_BIT]),
        .q     (status_s)
    );

    cdp_host_state_t  st_q;
    logic [CNT_W-1:0] cnt_q;

    assign wr_ready = (st_q == H_IDLE);
    assign rd_ready = (st_q == H_IDLE) & ~wr_valid;

    // Strobe held for a fixed width, select starts with the strobe and outlasts it; reads never overlap writes
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q                   <= H_IDLE;
            cnt_q                  <= '0;
            link.chip_select_low_n <= 1'b1;
            link.chip_select_high  <= 1'b0;
            link.write_strobe_n    <= 1'b1;
            link.read_strobe_n     <= 1'b1;
            link.host_data_out     <= BYTE_RST;
            link.host_data_oe      <= 1'b0;
            status_ready           <= 1'b0;
            status_valid           <= 1'b0;
        end
        else
        begin
            status_valid <= 1'b0;
            case (st_q)
                H_IDLE:
                begin
                    cnt_q <= '0;
                    if (wr_valid)
                    begin
                        st_q                   <= H_WRITE;
                        link.chip_select_low_n <= 1'b0;
                        link.chip_select_high  <= 1'b1;
                        link.write_strobe_n    <= 1'b0;
                        link.host_data_out     <= wr_byte;
                        link.host_data_oe      <= 1'b1;
                    end
                    else if (rd_valid)
                    begin
                        st_q                   <= H_READ;
                        link.chip_select_low_n <= 1'b0;
                        link.chip_select_high  <= 1'b1;
                        link.read_strobe_n     <= 1'b0;
                    end
                end
                H_WRITE, H_READ:
                begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (cnt_q == STROBE_LAST)
                    begin
                        if (st_q == H_READ)
                        begin
                            status_ready <= status_s;
                            status_valid <= 1'b1;
                        end
                        st_q                <= H_GAP;
                        cnt_q               <= '0;
                        link.write_strobe_n <= 1'b1;
                        link.read_strobe_n  <= 1'b1;
                    end
                end
                H_GAP:
                begin
                    // Data and select outlast the strobe by the gap
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (cnt_q == GAP_LAST)
                    begin
                        st_q                   <= H_IDLE;
                        link.chip_select_low_n <= 1'b1;
                        link.chip_select_high  <= 1'b0;
                        link.host_data_oe      <= 1'b0;
                    end
                end
                default:
                    st_q <= H_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0]  div_q;
    logic [DATA_W-1:0] ser_sh_q;
    logic [3:0]        ser_cnt_q;
    logic              half_end;

    assign half_end  = (div_q == HALF_LAST);
    assign ser_ready = (ser_cnt_q == 4'h0);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            div_q                    <= '0;
            link.configuration_clock <= 1'b0;
        end
        // Clock stands low between frames, so each frame gives exactly eight rises
        else if (ser_ready)
            div_q <= '0;
        else
        begin
            div_q <= half_end ? '0 : div_q + CNT_W'(1);
            if (half_end)
                link.configuration_clock <= ~link.configuration_clock;
        end
    end

    // First bit is set up before the first rise, later ones on falling edges, MSB first
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ser_sh_q       <= BYTE_RST;
            ser_cnt_q      <= 4'h0;
            link.serial_in <= 1'b0;
        end
        else if (ser_ready && ser_valid)
        begin
            ser_sh_q       <= {ser_byte[DATA_W-2:0], 1'b0};
            ser_cnt_q      <= 4'(DATA_W);
            link.serial_in <= ser_byte[DATA_W-1];
        end
        else if (!ser_ready && half_end && link.configuration_clock)
        begin
            link.serial_in <= ser_sh_q[DATA_W-1];
            ser_sh_q       <= {ser_sh_q[DATA_W-2:0], 1'b0};
            ser_cnt_q      <= ser_cnt_q - 4'h1;
        end
    end

endmodule : cdp_host

// ==== verif/cdp_assertions.sv ====
`timescale 1ns/100ps
module cdp_assertions
    import cdp_pkg::*;
(
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              chip_select_low_n,
    input wire logic              chip_select_high,
    input wire logic              write_strobe_n,
    input wire logic              read_strobe_n,
    input wire logic              configuration_clock,
    input wire logic              serial_out,
    input wire logic              host_data_oe,
    input wire logic [DATA_W-1:0] dev_data_oe,
    input wire logic [DATA_W-1:0] dev_data_out,
    input wire logic              init_out,
    input wire logic              init_oe
);
default clocking cb @(posedge clock);
endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////////
// Pins take two sync stages and a register, so four samples settle any drive
sequence s_read_held;
    (!chip_select_low_n && chip_select_high && !read_strobe_n && write_strobe_n) [*4];
endsequence
sequence s_both_low;
    (!write_strobe_n && !read_strobe_n) [*4];
endsequence
////////////////////////////////////////////////////////////////////////////////
a_read_fill: assert property (s_read_held |->
    dev_data_oe == 8'hFF && dev_data_out[6:0] == 7'h7F) else $error("read drive wrong");
a_write_wins: assert property (s_both_low |-> dev_data_oe == 8'h00)
    else $error("read drive during write");
a_read_release: assert property ($rose(read_strobe_n) |-> ##[1:5] dev_data_oe == 8'h00)
    else $error("data lines not released");
a_strobe_excl: assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("both strobes low");
a_select_write: assert property (!write_strobe_n |->
    !chip_select_low_n && chip_select_high && host_data_oe) else $error("write unselected");
a_strobe_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*8])
    else $error("write strobe too short");
a_init_drain: assert property (init_oe |-> !init_out)
    else $error("init driven high");
a_fwd_fall: assert property ($changed(serial_out) |-> !configuration_clock)
    else $error("forward changed on high clock");
endmodule : cdp_assertions

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench
    import cdp_pkg::*;
;
logic              clock, nrst, config_done, data_error, chain_enable;
logic              byte_valid, byte_ready, wr_valid, wr_ready, rd_valid, rd_ready;
logic              status_ready, status_valid, ser_valid, ser_ready;
logic [DATA_W-1:0] byte_data, wr_byte, ser_byte;
logic [PIN_W-1:0]  user_pins_in;
cdp_mode_t         mode;
int                num_errors = 0;
int                n_compared = 0;
cdp_if link_if();
cdp_device u_cdp_device (.clock(clock), .nrst(nrst), .link(link_if.dev), .mode(mode),
    .config_done(config_done), .data_error(data_error), .chain_enable(chain_enable),
    .byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .user_pins_in(user_pins_in), .user_data_in(), .user_data_out(8'h00),
    .user_data_oe(8'h00), .user_serial_out(1'b0), .user_address(22'h000000));
cdp_host u_cdp_host (.clock(clock), .nrst(nrst), .link(link_if.host), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .status_ready(status_ready), .status_valid(status_valid), .ser_valid(ser_valid),
    .ser_byte(ser_byte), .ser_ready(ser_ready));
cdp_assertions u_cdp_assertions (.clock(clock), .nrst(nrst),
    .chip_select_low_n(link_if.chip_select_low_n), .chip_select_high(link_if.chip_select_high),
    .write_strobe_n(link_if.write_strobe_n), .read_strobe_n(link_if.read_strobe_n),
    .configuration_clock(link_if.configuration_clock), .serial_out(link_if.serial_out),
    .host_data_oe(link_if.host_data_oe), .dev_data_oe(link_if.dev_data_oe),
    .dev_data_out(link_if.dev_data_out), .init_out(link_if.init_out),
    .init_oe(link_if.init_oe));
always #2.5 clock = ~clock;
////////////////////////////////////////////////////////////////////////////////
task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
    n_compared++;
    if (got !== exp)
    begin
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
endtask : check
task automatic restart(input cdp_mode_t m);
    nrst = 1'b0;
    mode = m;
    repeat (6) @(negedge clock);
    nrst = 1'b1;
endtask : restart
task automatic host_write(input logic [7:0] b);
    for (int i = 0; i < 100 && wr_ready !== 1'b1; i++) @(negedge clock);
    wr_valid = 1'b1;
    wr_byte = b;
    @(negedge clock);
    wr_valid = 1'b0;
endtask : host_write
task automatic host_read(output logic s);
    for (int i = 0; i < 100 && rd_ready !== 1'b1; i++) @(negedge clock);
    rd_valid = 1'b1;
    @(negedge clock);
    rd_valid = 1'b0;
    for (int i = 0; i < 100 && status_valid !== 1'b1; i++) @(negedge clock);
    s = status_ready;
endtask : host_read
// Waits for the whole frame, since the link clock cannot be stalled
task automatic ser_send(input logic [7:0] b);
    for (int i = 0; i < 900 && ser_ready !== 1'b1; i++) @(negedge clock);
    ser_valid = 1'b1;
    ser_byte = b;
    @(negedge clock);
    ser_valid = 1'b0;
    for (int i = 0; i < 900 && ser_ready !== 1'b1; i++) @(negedge clock);
    repeat (70) @(negedge clock);
endtask : ser_send
task automatic take(input logic [7:0] exp);
    for (int i = 0; i < 900 && byte_valid !== 1'b1; i++) @(negedge clock);
    check("byte_data", exp, byte_data);
    byte_ready = 1'b1;
    @(negedge clock);
    byte_ready = 1'b0;
endtask : take
task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask : finish_test
////////////////////////////////////////////////////////////////////////////////
initial
begin
    logic s;
    {clock, config_done, data_error, chain_enable, byte_ready} = '0;
    {wr_valid, rd_valid, ser_valid, wr_byte, ser_byte} = '0;
    restart(MODE_PERIPHERAL);
    host_read(s);
    check("status empty", 1'b1, s);
    host_write(8'hA5);
    host_read(s);
    check("status full", 1'b0, s);
    host_write(8'h5A);
    host_read(s);
    check("status still full", 1'b0, s);
    // Serial input idles low, so bit zero of the byte is cleared
    take(8'hA4);
    host_read(s);
    check("status after take", 1'b1, s);
    check("dropped write", 1'b0, byte_valid);
    $display("test peripheral done");
    restart(MODE_SLAVE_SERIAL);
    ser_send(8'h3C);
    take(8'h3C);
    check("forward first", 1'b0, link_if.serial_out);
    restart(MODE_MASTER_SERIAL);
    ser_send(8'hC3);
    take(8'hC3);
    check("forward second", 1'b1, link_if.serial_out);
    $display("test serial done");
    restart(MODE_MASTER_PARALLEL);
    byte_ready = 1'b1;
    ser_send(8'hA0);
    check("address", 22'h000008, {link_if.extra_address_out, link_if.memory_address_out});
    byte_ready = 1'b0;
    $display("test master parallel done");
    restart(MODE_EXPRESS);
    ser_send(8'h81);
    check("express idle", 1'b0, byte_valid);
    chain_enable = 1'b1;
    repeat (4) @(negedge clock);
    check("chain on", 1'b1, link_if.serial_out);
    chain_enable = 1'b0;
    data_error = 1'b1;
    repeat (4) @(negedge clock);
    check("chain off", 1'b0, link_if.serial_out);
    check("init low", 1'b0, link_if.init_line);
    config_done = 1'b1;
    repeat (4) @(negedge clock);
    check("init released", 1'b1, link_if.init_line);
    check("user pins", 4'hB, user_pins_in);
    $display("test express and done");
    finish_test();
end
initial
begin
    repeat (20000) @(posedge clock);
    num_errors++;
    finish_test();
end
endmodule : testbench
